// >>> common/id_phase_cfg.svh
// constants for the identification and phase count register slice
`ifndef ID_PHASE_CFG_SVH
`define ID_PHASE_CFG_SVH
// ==================================================
// command codes
`define CMD_BOARD_REV   8'h9B
`define CMD_BUILD_DATE  8'h9D
`define CMD_PART_ID     8'hAD
`define CMD_SILICON_REV 8'hAE
`define CMD_PHASE_COUNT 8'hD0
// ==================================================
// reset values and fixed fields
`define BOARD_REV_RST   16'h0000
`define BUILD_DATE_RST  24'h000000
`define PHASE_CODE_RST  3'h0
`define PRODUCT_CODE    8'h5A
`define SILICON_CODE    8'h01
`define PHASE_MAX_CODE  3'h7
`define PHASE_HW_MAX    3'h6
`endif

// >>> common/id_phase_pkg.sv
// types for the identification and phase count register slice
package id_phase_pkg;
	// ==================================================
	// register access request from the serial engine
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  cmd;
		logic [23:0] wdata;
	} reg_req_s;
endpackage

// >>> design/id_phase_regs.sv
// identification words and operating phase count registers
`timescale 1ns/1ps
`default_nettype none
`include "id_phase_cfg.svh"

// What this block does
// - a 16-bit board revision word is kept and returned by block write and block read.
// - the part identifier reads as a fixed product byte over the configuration revision byte.
// - the silicon revision word reads as a fixed silicon byte over the configuration revision byte.
// - phase codes 1 to 6 run that many phases, capped at the strap limit, and codes 0 and 7 run the maximum available.
// - with auto shedding on, phase count writes are ignored and reads give the phases in use.
// - auto shedding is on only when its pin sees a resistor to ground, not a short.
module id_phase_regs
	import id_phase_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// register access
	input  wire reg_req_s   req,
	output logic [23:0]     rdata,
	output logic            rvalid,
	// pins and status
	input  wire logic [5:0] phase_strap_high,
	input  wire logic       shed_pin_resistor,
	input  wire logic       shed_pin_shorted,
	input  wire logic [2:0] shed_phases_now,
	input  wire logic [7:0] config_revision,
	output logic [2:0]      phases_run,
	output logic            shed_enabled
);
	// ==================================================
	// pin synchronisers
	// each pin bit has its own two-stage chain; logic reads only the second stage
	localparam int PIN_BITS = 8;
	logic [PIN_BITS-1:0] pin_raw;
	logic [PIN_BITS-1:0] pin_sync;
	logic [5:0]          strap_sync;
	logic                res_sync;
	logic                short_sync;

	assign pin_raw = {shed_pin_shorted, shed_pin_resistor, phase_strap_high};

	genvar g;
	generate
		for (g = 0; g < PIN_BITS; g = g + 1) begin : g_sync
			logic s1_q;
			logic s1_d;
			logic s2_q;
			logic s2_d;
			always_comb begin
				s1_d = pin_raw[g];
				s2_d = s1_q;
			end
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
				end else if (clk_en) begin
					s1_q <= s1_d;
					s2_q <= s2_d;
				end
			end
			assign pin_sync[g] = s2_q;
		end
	endgenerate

	assign strap_sync = pin_sync[5:0];
	assign res_sync   = pin_sync[6];
	assign short_sync = pin_sync[7];

	// ==================================================
	// command decode
	localparam int SEL_BOARD   = 0;
	localparam int SEL_DATE    = 1;
	localparam int SEL_PART    = 2;
	localparam int SEL_SILICON = 3;
	localparam int SEL_PHASE   = 4;

	// one-hot select; the write and the read path share it so they cannot disagree
	function automatic logic [4:0] reg_select(input logic [7:0] cmd);
		logic [4:0] sel;
		sel = 5'h00;
		if (cmd == `CMD_BOARD_REV) begin
			sel[SEL_BOARD] = 1'b1;
		end else if (cmd == `CMD_BUILD_DATE) begin
			sel[SEL_DATE] = 1'b1;
		end else if (cmd == `CMD_PART_ID) begin
			sel[SEL_PART] = 1'b1;
		end else if (cmd == `CMD_SILICON_REV) begin
			sel[SEL_SILICON] = 1'b1;
		end else if (cmd == `CMD_PHASE_COUNT) begin
			sel[SEL_PHASE] = 1'b1;
		end
		return sel;
	endfunction

	// first strapped-high output caps the count below it
	function automatic logic [2:0] limit_from_straps(input logic [5:0] hi);
		logic [2:0] n;
		n = `PHASE_HW_MAX;
		for (int i = 5; i >= 0; i--) begin
			if (hi[i]) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction

	logic [4:0] wr_sel;
	logic [4:0] rd_sel;

	assign wr_sel = req.wr ? reg_select(req.cmd) : 5'h00;
	assign rd_sel = req.rd ? reg_select(req.cmd) : 5'h00;

	// ==================================================
	// shedding enable
	logic shed_q;
	logic shed_d;

	always_comb begin
		// a shorted pin overrides the resistor sense
		shed_d = res_sync & ~short_sync;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shed_q <= 1'b0;
		end else if (clk_en) begin
			shed_q <= shed_d;
		end
	end

	// ==================================================
	// user storage words
	logic [15:0] board_rev_q;
	logic [15:0] board_rev_d;
	logic [23:0] build_date_q;
	logic [23:0] build_date_d;

	always_comb begin
		board_rev_d  = board_rev_q;
		build_date_d = build_date_q;
		if (wr_sel[SEL_BOARD]) begin
			board_rev_d = req.wdata[15:0];
		end
		if (wr_sel[SEL_DATE]) begin
			build_date_d = req.wdata;
		end
		// part id and silicon revision have no write path at all
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			board_rev_q  <= `BOARD_REV_RST;
			build_date_q <= `BUILD_DATE_RST;
		end else if (clk_en) begin
			board_rev_q  <= board_rev_d;
			build_date_q <= build_date_d;
		end
	end

	// ==================================================
	// operating phase count
	logic [2:0] phase_code_q;
	logic [2:0] phase_code_d;
	logic [2:0] run_q;
	logic [2:0] run_d;
	logic [2:0] max_phase_limit;
	logic [2:0] requested;

	always_comb begin
		max_phase_limit = limit_from_straps(strap_sync);
		if ((phase_code_q == 3'h0) || (phase_code_q == `PHASE_MAX_CODE)) begin
			requested = max_phase_limit;
		end else if (phase_code_q > max_phase_limit) begin
			requested = max_phase_limit;
		end else begin
			requested = phase_code_q;
		end
		// shedding owns the count; the stored code returns once shedding is off
		run_d = shed_q ? shed_phases_now : requested;
		phase_code_d = phase_code_q;
		if (wr_sel[SEL_PHASE] && !shed_q) begin
			// write timing is the host's duty; not policed here
			phase_code_d = req.wdata[2:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase_code_q <= `PHASE_CODE_RST;
			run_q        <= 3'h0;
		end else if (clk_en) begin
			phase_code_q <= phase_code_d;
			run_q        <= run_d;
		end
	end

	// ==================================================
	// read answer
	logic [23:0] rdata_q;
	logic [23:0] rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;

	always_comb begin
		rvalid_d = req.rd;
		// data is held at zero outside the answer cycle
		rdata_d  = 24'h000000;
		if (rd_sel[SEL_BOARD]) begin
			rdata_d = {8'h00, board_rev_q};
		end else if (rd_sel[SEL_DATE]) begin
			rdata_d = build_date_q;
		end else if (rd_sel[SEL_PART]) begin
			rdata_d = {8'h00, `PRODUCT_CODE, config_revision};
		end else if (rd_sel[SEL_SILICON]) begin
			rdata_d = {8'h00, `SILICON_CODE, config_revision};
		end else if (rd_sel[SEL_PHASE]) begin
			rdata_d = {21'h00000, shed_q ? run_q : phase_code_q};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q  <= 24'h000000;
			rvalid_q <= 1'b0;
		end else if (clk_en) begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ==================================================
	// outputs
	assign rdata        = rdata_q;
	assign rvalid       = rvalid_q;
	assign phases_run   = run_q;
	assign shed_enabled = shed_q;
endmodule
`default_nettype wire

// >>> dv/host_model.sv
// host request driver in place of the serial engine
`timescale 1ns/1ps
`default_nettype none
module host_model
	import id_phase_pkg::*;
(
	// clock and request
	input wire logic clock,
	output var reg_req_s req
);
	initial req = '0;
	// on release wr and rd drop to zero and the command and data lines show inverted values, so stale data is never mistaken for valid
	task automatic put(input logic w, input logic [7:0] c, input logic [23:0] d);
		// soft-start and voltage changes lie outside this slice; callers issue phase writes only after pins settle
		@(posedge clock) #1 req = '{w, !w, c, d};
		@(posedge clock) #1 req = '{1'b0, 1'b0, ~c, ~d};
	endtask
endmodule
`default_nettype wire

// >>> dv/id_phase_regs_asserts.sv
// port assertions for the id and phase count registers
`timescale 1ns/1ps
`default_nettype none
`include "id_phase_cfg.svh"
module id_phase_regs_asserts
	import id_phase_pkg::*;
(
	// clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        clk_en,
	// register access
	input wire reg_req_s    req,
	input wire logic [23:0] rdata,
	input wire logic        rvalid,
	// pins and status
	input wire logic        shed_pin_resistor,
	input wire logic        shed_pin_shorted,
	input wire logic [7:0]  config_revision,
	input wire logic [2:0]  phases_run,
	input wire logic        shed_enabled
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_rd(c);
		clk_en && req.rd && req.cmd == c;
	endsequence
	a_read_answer: assert property (clk_en && req.rd |=> rvalid)
		else $error("read not answered");
	a_no_stray: assert property (rvalid && $past(clk_en) |-> $past(req.rd))
		else $error("answer without read");
	a_part_id: assert property (s_rd(`CMD_PART_ID) |=> rdata == {8'h00, `PRODUCT_CODE, $past(config_revision)})
		else $error("bad part id");
	a_silicon_rev: assert property (s_rd(`CMD_SILICON_REV) |=> rdata == {8'h00, `SILICON_CODE, $past(config_revision)})
		else $error("bad silicon rev");
	a_shed_on: assert property ((shed_pin_resistor && !shed_pin_shorted) [*4] |=> shed_enabled)
		else $error("shedding not on");
	a_shed_short: assert property (shed_pin_shorted [*4] |=> !shed_enabled)
		else $error("short enabled shedding");
	a_phase_max: assert property (phases_run <= `PHASE_HW_MAX)
		else $error("phase count too high");
	a_shed_read: assert property (s_rd(`CMD_PHASE_COUNT) ##0 shed_enabled |=> rdata == {21'h0, $past(phases_run)})
		else $error("shed read wrong");
endmodule
`default_nettype wire

// >>> dv/tb_id_phase_regs.sv
// self-checking bench for the id and phase count registers
`timescale 1ns/1ps
`default_nettype none
`include "id_phase_cfg.svh"
module tb_id_phase_regs;
	import id_phase_pkg::*;
	logic clock = 0, reset_n = 0, clk_en = 1, rvalid, shed_enabled, shed_res = 0, shed_short = 0;
	logic [5:0] strap = 0;
	logic [2:0] shed_now = 3'h4, phases_run;
	logic [23:0] rdata;
	reg_req_s req;
	int err_total = 0, comparisons = 0;
	logic [55:0] rows [5] = '{{`CMD_BOARD_REV, 24'h001234, 24'h001234}, {`CMD_BUILD_DATE, 24'hABCDEF, 24'hABCDEF},
		{`CMD_PART_ID, 24'hFFFFFF, 16'h005A, 8'hC3}, {`CMD_SILICON_REV, 24'hFFFFFF, 16'h0001, 8'hC3},
		{`CMD_PHASE_COUNT, 24'h000003, 24'h000003}};
	host_model i_host_model (.clock(clock), .req(req));
	id_phase_regs i_id_phase_regs (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .req(req), .rdata(rdata),
		.rvalid(rvalid), .phase_strap_high(strap), .shed_pin_resistor(shed_res), .shed_pin_shorted(shed_short),
		.shed_phases_now(shed_now), .config_revision(8'hC3), .phases_run(phases_run), .shed_enabled(shed_enabled));
	initial forever #2.5 clock = ~clock;
	task automatic cmp(input logic [23:0] a, e);
		comparisons++;
		if (a !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic [23:0] e);
		i_host_model.put(0, c, 24'h0);
		cmp(rvalid, 1);
		cmp(rdata, e);
	endtask
	task automatic run_is(input logic [2:0] e);
		for (int n = 0; n < 8 && phases_run !== e; n++) @(posedge clock) #1;
		cmp(phases_run, e);
	endtask
	task automatic end_sim;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock) #1;
		cmp({rvalid, phases_run}, 0);
		reset_n = 1;
		rd(`CMD_BOARD_REV, 0);
		foreach (rows[i]) begin
			i_host_model.put(1, rows[i][55:48], rows[i][47:24]);
			rd(rows[i][55:48], rows[i][23:0]);
		end
		rd(8'h55, 0);
		clk_en = 0;
		i_host_model.put(1, `CMD_BOARD_REV, 24'h005555);
		clk_en = 1;
		rd(`CMD_BOARD_REV, 24'h001234);
		for (int c = 0; c < 8; c++) begin
			i_host_model.put(1, `CMD_PHASE_COUNT, 24'(c));
			run_is(c inside {[1:6]} ? 3'(c) : `PHASE_HW_MAX);
		end
		strap = 6'h20;
		i_host_model.put(1, `CMD_PHASE_COUNT, 24'h6);
		run_is(3'h5);
		shed_res = 1;
		shed_short = 1;
		repeat (6) @(posedge clock) #1;
		cmp(shed_enabled, 0);
		shed_short = 0;
		repeat (6) @(posedge clock) #1;
		cmp(shed_enabled, 1);
		i_host_model.put(1, `CMD_PHASE_COUNT, 24'h2);
		run_is(3'h4);
		rd(`CMD_PHASE_COUNT, 24'h4);
		shed_res = 0;
		run_is(3'h5);
		reset_n = 0;
		#1 cmp({rvalid, phases_run, shed_enabled}, 0);
		@(posedge clock) #1 reset_n = 1;
		rd(`CMD_BOARD_REV, 0);
		end_sim;
	end
endmodule
bind id_phase_regs id_phase_regs_asserts i_id_phase_regs_asserts (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
	.req(req), .rdata(rdata), .rvalid(rvalid), .shed_pin_resistor(shed_pin_resistor),
	.shed_pin_shorted(shed_pin_shorted), .config_revision(config_revision), .phases_run(phases_run),
	.shed_enabled(shed_enabled));
`default_nettype wire
